/* core/tlsa_core.sv */
// limit checking, status flags, alarm outputs and conversion scheduling of a three-channel monitor
//
// How it works
// - rate code 0..10 doubles from 1/16 to 64 per second; 11 continuous; reset 7.
// - rate bit 7 set turns averaging off; fastest three periodic rates never average.
// - channel field 00 all channels, 01 local, 10 remote 1, 11 remote 2.
// - every channel has high, low, overtemp limits; remote high/low span two bytes.
// - a result at or below the low limit sets the low flag.
// - overtemp output goes low when any result exceeds its overtemp limit.
// - one hysteresis, default 10, releases overtemp outputs below limit minus hysteresis.
// - limits compare raw in measurement format; no conversion on scale change.
// - both status registers are read-only; writes are ignored.
// - status 1: busy, local high/low, remote 1 high/low/open/overtemp, local overtemp.
// - status 2: remote 2 high/low/open/overtemp, and interrupt-asserted in bit 0.
// - high, low and open flags stay set until their status register is read.
// - unmasked interrupt-capable flags are ORed into the interrupt latch, output low.
// - status read clears its latched flags only where the condition has gone.
// - status reads keep the latch; address read clears it once causes are gone.
// - overtemp output follows the overtemp flags and releases without host help.
// - as second overtemp output the shared pin follows only high-limit flags.
// - status 2 bit 0 mirrors an asserted interrupt output, clear while masked.
// - remote offsets are 10-bit signed: upper byte, two left-justified low bits.
// - signed offset is added to the remote result before storing and comparing.
// - remote select bit steers remote 1 offset addresses to remote 2 offsets.
// - config bit 7 masks the interrupt; bits 1 and 0 mask remote causes.
// - config bit 5 picks shared pin role: interrupt or second overtemp output.
// - config bit 6 is standby: no new conversion sequences, registers live, outputs not valid.
`timescale 1ns/1ps
`default_nettype none

module tlsa_core
  import tlsa_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire tlsa_req_t  reg_req,
  output logic [7:0]      reg_rdata,
  input  wire logic       addr_read_ack,
  output logic            adc_start,
  output logic [1:0]      adc_chan,
  output logic            adc_avg_en,
  input  wire tlsa_meas_t meas,
  output logic            overtemp_out_n,
  output logic            shared_pin_n
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic f_above(input logic [9:0] v, input logic [9:0] lim);
    return v > lim;
  endfunction

  function automatic logic f_released(input logic [7:0] t, input logic [7:0] lim, input logic [7:0] hy);
    return ({1'b0, t} + {1'b0, hy}) < {1'b0, lim};
  endfunction

  logic [7:0]  cfg1_r;
  logic [7:0]  rate_r;
  logic [9:0]  high_r [3];
  logic [9:0]  low_r  [3];
  logic [7:0]  overtemp_out_n_r [3];
  logic [7:0]  hyst_r;
  logic [9:0]  ofs_r  [2];
  logic [9:0]  temp_r [3];
  logic [2:0]  hi_f_r, lo_f_r, open_f_r, open_now_r, th_r, th2_r;
  logic        alert_latch_r;
  tlsa_state_t state_r;
  logic [1:0]  cur_ch_r;
  logic [TW-1:0] tick_cnt_r;
  logic [10:0] per_cnt_r;
  logic        due_r;
  logic [7:0]  rdata_r;
  logic        ot_n_r, sp_n_r;

  logic       standby, cont, tick, done, rem_sel, start_seq, last_ch;
  logic [1:0] ri;
  logic [1:0] first_ch;
  logic [11:0] corr;
  logic [9:0] nv;
  logic       rd_st1, rd_st2, any_cause, alert_act, meas_ok;
  logic [2:0] hi_now, lo_now;
  logic [7:0] status1, status2, rd_val;

  assign standby = cfg1_r[CFG_STANDBY];
  assign rem_sel = cfg1_r[CFG_REM_SEL];
  assign ri      = rem_sel ? 2'd2 : 2'd1;
  assign cont    = rate_r[3:0] > RATE_FASTEST;
  assign rd_st1  = reg_req.rd && reg_req.addr == A_STATUS1;
  assign rd_st2  = reg_req.rd && reg_req.addr == A_STATUS2;
  assign done    = state_r == S_WAIT && meas.valid;
  assign meas_ok = !meas.open || cur_ch_r == 2'd0; // local channel has no diode to open

  // ---- configuration and limit registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg1_r <= RST_CFG1;
      rate_r <= RST_RATE;
      hyst_r <= RST_HYST;
      for (int i = 0; i < 3; i++) begin
        high_r[i]  <= {RST_HIGH, 2'b00};
        low_r[i]   <= {RST_LOW, 2'b00};
        overtemp_out_n_r[i] <= RST_OVERTEMP_OUT_N;
      end
      ofs_r[0] <= '0;
      ofs_r[1] <= '0;
    end else if (reg_req.wr) begin
      // status addresses have no write decode, so writes there fall through
      case (reg_req.addr)
        A_CFG1_WR:        cfg1_r <= reg_req.wdata;
        A_RATE_WR:        rate_r <= {reg_req.wdata[7], 1'b0, reg_req.wdata[5:0]};
        A_LOC_HIGH_WR:    high_r[0][9:2] <= reg_req.wdata;
        A_LOC_LOW_WR:     low_r[0][9:2] <= reg_req.wdata;
        A_REM_HIGH_HI_WR: high_r[ri][9:2] <= reg_req.wdata;
        A_REM_HIGH_LO:    high_r[ri][1:0] <= reg_req.wdata[7:6];
        A_REM_LOW_HI_WR:  low_r[ri][9:2] <= reg_req.wdata;
        A_REM_LOW_LO:     low_r[ri][1:0] <= reg_req.wdata[7:6];
        A_LOC_OVERTEMP_OUT_N:      overtemp_out_n_r[0] <= reg_req.wdata;
        A_REM_OVERTEMP_OUT_N:      overtemp_out_n_r[ri] <= reg_req.wdata;
        A_HYST:           hyst_r <= reg_req.wdata;
        A_REM1_OFS_HI:    ofs_r[rem_sel][9:2] <= reg_req.wdata;
        A_REM1_OFS_LO:    ofs_r[rem_sel][1:0] <= reg_req.wdata[7:6];
        A_REM2_OFS_HI:    ofs_r[1][9:2] <= reg_req.wdata;
        A_REM2_OFS_LO:    ofs_r[1][1:0] <= reg_req.wdata[7:6];
        default: ;
      endcase
    end
  end

  // ---- conversion scheduling
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end
  assign tick = tick_cnt_r == TW'(TICK_CYCLES - 1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      per_cnt_r <= '0;
      due_r     <= 1'b0;
    end else begin
      if (tick) begin
        if (per_cnt_r >= (RATE_SLOWEST_TICKS >> rate_r[3:0]) - 11'd1) begin
          per_cnt_r <= '0;
        end else begin
          per_cnt_r <= per_cnt_r + 11'd1;
        end
      end
      if (tick && per_cnt_r >= (RATE_SLOWEST_TICKS >> rate_r[3:0]) - 11'd1) begin
        due_r <= 1'b1;
      end else if (start_seq) begin
        due_r <= 1'b0;
      end
    end
  end

  assign first_ch  = (rate_r[5:4] == 2'b00) ? 2'd0 : rate_r[5:4] - 2'd1;
  assign last_ch   = rate_r[5:4] != 2'b00 || cur_ch_r == 2'd2;
  // standby only blocks new sequences; a conversion under way is allowed to finish
  assign start_seq = state_r == S_IDLE && !standby && (due_r || cont);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r  <= S_IDLE;
      cur_ch_r <= 2'd0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start_seq) begin
            cur_ch_r <= first_ch;
            state_r  <= S_START;
          end
        end
        S_START: state_r <= S_WAIT;
        S_WAIT: begin
          if (meas.valid) begin
            if (last_ch) begin
              state_r <= S_IDLE;
            end else begin
              cur_ch_r <= cur_ch_r + 2'd1;
              state_r  <= S_START;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  assign adc_start  = state_r == S_START;
  assign adc_chan   = cur_ch_r;
  assign adc_avg_en = !rate_r[RATE_AVG_OFF] && (rate_r[3:0] <= RATE_LAST_AVG || cont);

  // ---- offset correction, clamped to the 10-bit range rather than wrapping
  always_comb begin
    corr = {2'b00, meas.val[9:2], 2'b00}; // local result is whole degrees only
    if (cur_ch_r != 2'd0) begin
      corr = {2'b00, meas.val} + {{2{ofs_r[cur_ch_r[1]][9]}}, ofs_r[cur_ch_r[1]]};
    end
    if (corr[11]) begin
      nv = '0;
    end else if (corr[10]) begin
      nv = 10'h3ff;
    end else begin
      nv = corr[9:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        temp_r[i] <= '0;
      end
      open_now_r <= '0;
    end else if (done) begin
      open_now_r[cur_ch_r] <= meas.open && cur_ch_r != 2'd0;
      if (meas_ok) begin
        temp_r[cur_ch_r] <= (cur_ch_r == 2'd0) ? {nv[9:2], 2'b00} : nv;
      end
    end
  end

  // ---- latched status flags
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hi_now[i] = f_above(temp_r[i], high_r[i]);
      lo_now[i] = temp_r[i] <= low_r[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hi_f_r   <= '0;
      lo_f_r   <= '0;
      open_f_r <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // a new set in the clearing cycle wins over the read
        if (done && cur_ch_r == 2'(i) && meas_ok && f_above(nv, high_r[i])) begin
          hi_f_r[i] <= 1'b1;
        end else if (((i == 2) ? rd_st2 : rd_st1) && !hi_now[i]) begin
          hi_f_r[i] <= 1'b0;
        end
        if (done && cur_ch_r == 2'(i) && meas_ok && nv <= low_r[i]) begin
          lo_f_r[i] <= 1'b1;
        end else if (((i == 2) ? rd_st2 : rd_st1) && !lo_now[i]) begin
          lo_f_r[i] <= 1'b0;
        end
        if (i != 0 && done && cur_ch_r == 2'(i) && meas.open) begin
          open_f_r[i] <= 1'b1;
        end else if (((i == 2) ? rd_st2 : rd_st1) && !open_now_r[i]) begin
          open_f_r[i] <= 1'b0;
        end
      end
    end
  end

  // ---- overtemp flags with hysteresis, self-clearing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      th_r  <= '0;
      th2_r <= '0;
    end else if (done && meas_ok) begin
      if (nv[9:2] > overtemp_out_n_r[cur_ch_r]) begin
        th_r[cur_ch_r] <= 1'b1;
      end else if (f_released(nv[9:2], overtemp_out_n_r[cur_ch_r], hyst_r)) begin
        th_r[cur_ch_r] <= 1'b0;
      end
      if (f_above(nv, high_r[cur_ch_r])) begin
        th2_r[cur_ch_r] <= 1'b1;
      end else if (f_released(nv[9:2], high_r[cur_ch_r][9:2], hyst_r)) begin
        th2_r[cur_ch_r] <= 1'b0;
      end
    end
  end

  // ---- interrupt latch
  assign any_cause = hi_f_r[0] || lo_f_r[0]
                  || (!cfg1_r[CFG_REM_ONE_IRQ_BLOCK] && (hi_f_r[1] || lo_f_r[1] || open_f_r[1]))
                  || (!cfg1_r[CFG_REM_TWO_IRQ_BLOCK] && (hi_f_r[2] || lo_f_r[2] || open_f_r[2]));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alert_latch_r <= 1'b0;
    end else if (any_cause) begin
      alert_latch_r <= 1'b1;
    end else if (addr_read_ack) begin
      alert_latch_r <= 1'b0;
    end
  end

  assign alert_act = alert_latch_r && !cfg1_r[CFG_MASK_ALL] && !cfg1_r[CFG_ROLE] && !standby;

  // ---- pins; released in standby since their state is not meaningful there
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ot_n_r <= 1'b1;
      sp_n_r <= 1'b1;
    end else begin
      ot_n_r <= standby || !(|th_r);
      if (cfg1_r[CFG_ROLE]) begin
        sp_n_r <= standby || !(|th2_r);
      end else begin
        sp_n_r <= !alert_act;
      end
    end
  end
  assign overtemp_out_n = ot_n_r;
  assign shared_pin_n   = sp_n_r;

  // ---- register reads
  assign status1 = {state_r != S_IDLE, hi_f_r[0], lo_f_r[0], hi_f_r[1], lo_f_r[1],
                    open_f_r[1], th_r[1], th_r[0]};
  assign status2 = {3'b000, hi_f_r[2], lo_f_r[2], open_f_r[2], th_r[2], alert_act};

  always_comb begin
    case (reg_req.addr)
      A_LOC_TEMP:       rd_val = temp_r[0][9:2];
      A_REM_TEMP_HI:    rd_val = temp_r[ri][9:2];
      A_REM_TEMP_LO:    rd_val = {temp_r[ri][1:0], 6'h00};
      A_REM2_TEMP_HI:   rd_val = temp_r[2][9:2];
      A_REM2_TEMP_LO:   rd_val = {temp_r[2][1:0], 6'h00};
      A_STATUS1:        rd_val = status1;
      A_STATUS2:        rd_val = status2;
      A_CFG1_RD:        rd_val = cfg1_r;
      A_RATE_RD:        rd_val = rate_r;
      A_LOC_HIGH_RD:    rd_val = high_r[0][9:2];
      A_LOC_LOW_RD:     rd_val = low_r[0][9:2];
      A_REM_HIGH_HI_RD: rd_val = high_r[ri][9:2];
      A_REM_LOW_HI_RD:  rd_val = low_r[ri][9:2];
      A_REM_HIGH_LO:    rd_val = {high_r[ri][1:0], 6'h00};
      A_REM_LOW_LO:     rd_val = {low_r[ri][1:0], 6'h00};
      A_LOC_OVERTEMP_OUT_N:      rd_val = overtemp_out_n_r[0];
      A_REM_OVERTEMP_OUT_N:      rd_val = overtemp_out_n_r[ri];
      A_HYST:           rd_val = hyst_r;
      A_REM1_OFS_HI:    rd_val = ofs_r[rem_sel][9:2];
      A_REM1_OFS_LO:    rd_val = {ofs_r[rem_sel][1:0], 6'h00};
      A_REM2_OFS_HI:    rd_val = ofs_r[1][9:2];
      A_REM2_OFS_LO:    rd_val = {ofs_r[1][1:0], 6'h00};
      default:          rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      rdata_r <= rd_val;
    end
  end
  assign reg_rdata = rdata_r;

  // ---- checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_rate_default:  assert property ($rose(rst_n) |-> rate_r == RST_RATE && hyst_r == RST_HYST)
    else $error("rate or hysteresis not at reset value");
  a_low_flag_set:  assert property (done && cur_ch_r == 2'd0 && nv <= low_r[0] |=> lo_f_r[0])
    else $error("low flag not set at or below low limit");
  a_overtemp_out_n_pin:     assert property (|th_r && !standby && $stable(cfg1_r) |=> !overtemp_out_n)
    else $error("overtemp pin not low with overtemp flag");
  a_overtemp_out_n_hold:    assert property (th_r[0] && !(done && cur_ch_r == 2'd0) |=> th_r[0])
    else $error("overtemp flag released without a conversion");
  a_status_ro:     assert property (reg_req.wr && reg_req.addr == A_STATUS1 && !done && !reg_req.rd
                                    |=> $stable(hi_f_r) && $stable(lo_f_r))
    else $error("status write changed flags");
  a_flag_hold:     assert property (hi_f_r[1] && !rd_st1 |=> hi_f_r[1])
    else $error("latched flag dropped without status read");
  a_latch_hold:    assert property (alert_latch_r && !addr_read_ack |=> alert_latch_r)
    else $error("interrupt latch cleared without address read");
  a_masked_bit:    assert property (cfg1_r[CFG_MASK_ALL] |-> !status2[0])
    else $error("interrupt status bit set while masked");
  a_single_chan:   assert property (start_seq && rate_r[5:4] == 2'b10
                                    |=> adc_start && adc_chan == 2'd1 ##1 !adc_start)
    else $error("single-channel mode started wrong channel");
  a_second_pin:    assert property (cfg1_r[CFG_ROLE] && !(|th2_r) && $stable(cfg1_r) |=> shared_pin_n)
    else $error("second overtemp pin low without high flag");

  c_alert_raised:  cover property (!shared_pin_n && !cfg1_r[CFG_ROLE]);
  c_overtemp_out_n_cycle:   cover property (!overtemp_out_n ##[1:1000] overtemp_out_n);
  c_round_robin:   cover property (adc_start && adc_chan == 2'd2 && rate_r[5:4] == 2'b00);
  c_latch_cleared: cover property (alert_latch_r ##1 !alert_latch_r);

endmodule : tlsa_core

`default_nettype wire

/* core/tlsa_pkg.sv */
// package: register map, reset values, field positions and carriers for the limit/status block
package tlsa_pkg;

  // register addresses; several registers read and write at different addresses
  localparam logic [7:0] A_LOC_TEMP       = 8'h00;
  localparam logic [7:0] A_REM_TEMP_HI    = 8'h01;
  localparam logic [7:0] A_STATUS1        = 8'h02;
  localparam logic [7:0] A_CFG1_RD        = 8'h03;
  localparam logic [7:0] A_RATE_RD        = 8'h04;
  localparam logic [7:0] A_LOC_HIGH_RD    = 8'h05;
  localparam logic [7:0] A_LOC_LOW_RD     = 8'h06;
  localparam logic [7:0] A_REM_HIGH_HI_RD = 8'h07;
  localparam logic [7:0] A_REM_LOW_HI_RD  = 8'h08;
  localparam logic [7:0] A_CFG1_WR        = 8'h09;
  localparam logic [7:0] A_RATE_WR        = 8'h0a;
  localparam logic [7:0] A_LOC_HIGH_WR    = 8'h0b;
  localparam logic [7:0] A_LOC_LOW_WR     = 8'h0c;
  localparam logic [7:0] A_REM_HIGH_HI_WR = 8'h0d;
  localparam logic [7:0] A_REM_LOW_HI_WR  = 8'h0e;
  localparam logic [7:0] A_REM_TEMP_LO    = 8'h10;
  localparam logic [7:0] A_REM1_OFS_HI    = 8'h11;
  localparam logic [7:0] A_REM1_OFS_LO    = 8'h12;
  localparam logic [7:0] A_REM_HIGH_LO    = 8'h13;
  localparam logic [7:0] A_REM_LOW_LO     = 8'h14;
  localparam logic [7:0] A_REM_OVERTEMP_OUT_N      = 8'h19;
  localparam logic [7:0] A_LOC_OVERTEMP_OUT_N      = 8'h20;
  localparam logic [7:0] A_HYST           = 8'h21;
  localparam logic [7:0] A_STATUS2        = 8'h23;
  localparam logic [7:0] A_REM2_TEMP_HI   = 8'h30;
  localparam logic [7:0] A_REM2_TEMP_LO   = 8'h33;
  localparam logic [7:0] A_REM2_OFS_HI    = 8'h34;
  localparam logic [7:0] A_REM2_OFS_LO    = 8'h35;

  // reset values
  localparam logic [7:0] RST_CFG1  = 8'h00;
  localparam logic [7:0] RST_RATE  = 8'h07;
  localparam logic [7:0] RST_HIGH  = 8'h55;
  localparam logic [7:0] RST_LOW   = 8'h00;
  localparam logic [7:0] RST_OVERTEMP_OUT_N = 8'h55;
  localparam logic [7:0] RST_HYST  = 8'h0a;

  // configuration 1 and rate field positions
  localparam int CFG_MASK_ALL = 7;
  localparam int CFG_STANDBY  = 6;
  localparam int CFG_ROLE     = 5;
  localparam int CFG_REM_SEL  = 3;
  localparam int CFG_REM_ONE_IRQ_BLOCK  = 1;
  localparam int CFG_REM_TWO_IRQ_BLOCK  = 0;
  localparam int RATE_AVG_OFF = 7;
  localparam logic [3:0] RATE_LAST_AVG = 4'h7;
  localparam logic [3:0] RATE_FASTEST  = 4'ha;
  localparam logic [10:0] RATE_SLOWEST_TICKS = 11'h400;

  // base tick: one period of the fastest rate, 1/64 s
  localparam longint TICK_NS  = 15625000;
  localparam longint CLK_NS   = 5;
  localparam int     TICK_CYC = int'(TICK_NS / CLK_NS);

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlsa_req_t;

  typedef struct packed {
    logic       valid;
    logic       open;
    logic [9:0] val;
  } tlsa_meas_t;

  typedef enum {S_IDLE, S_START, S_WAIT} tlsa_state_t;

endpackage : tlsa_pkg

/* test/tb.sv */
// self-checking bench for the limit, status and alarm core
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tlsa_pkg::*;
  logic clock, rst_n, ack, adc_start, avg_en, ot_n, sh_n;
  logic [7:0] rdata;
  logic [1:0] adc_chan;
  logic [9:0] v0, v1, v2;
  logic [2:0] open_m;
  logic [3:0] lat;
  tlsa_req_t  req;
  tlsa_meas_t meas;
  int mismatches, cmp_count, cyc;

  tlsa_core #(.TICK_CYCLES(20)) DUT (.clock(clock), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .addr_read_ack(ack), .adc_start(adc_start), .adc_chan(adc_chan), .adc_avg_en(avg_en), .meas(meas),
    .overtemp_out_n(ot_n), .shared_pin_n(sh_n));
  tlsa_fe_model fe (.clock(clock), .rst_n(rst_n), .adc_start(adc_start), .adc_chan(adc_chan), .val_loc(v0),
    .val_r1(v1), .val_r2(v2), .open_mask(open_m), .lat(lat), .meas(meas));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    #1;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1;
    chk(nm, {2'b00, rdata & m}, {2'b00, e});
  endtask

  // wait for n finished conversions, then let the pins settle
  task automatic conv(input int n);
    int k, g;
    k = 0;
    g = 0;
    while (k < n && g < 5000) begin
      @(posedge clock);
      g++;
      if (meas.valid === 1'b1) k++;
    end
    chk("conv_done", k[9:0], n[9:0]);
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic nstart(input logic [1:0] e);
    int g;
    g = 0;
    do begin
      @(posedge clock);
      g++;
    end while (adc_start !== 1'b1 && g < 500);
    chk("adc_chan", {8'h00, adc_chan}, {8'h00, e});
  endtask

  task automatic rst(input logic [7:0] rate, input logic [3:0] l);
    @(posedge clock);
    rst_n  <= 1'b0;
    v0     <= 10'h100;
    v1     <= 10'h100;
    v2     <= 10'h100;
    open_m <= 3'b000;
    lat    <= l;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    if (rate != RST_RATE) wr(A_RATE_WR, rate);
  endtask

  task automatic setloc(input logic [9:0] v);
    @(posedge clock);
    v0 <= v;
    conv(4);
  endtask

  task automatic s_regs();
    rst(RST_RATE, 4'd3);
    #1;
    chk("avg_rst", avg_en, 1'b1);
    chk("ot_rst", ot_n, 1'b1);
    rchk("rate_rst", A_RATE_RD, 8'hff, 8'h07);
    rchk("cfg1_rst", A_CFG1_RD, 8'hff, 8'h00);
    rchk("hyst_rst", A_HYST, 8'hff, 8'h0a);
    rchk("high_rst", A_LOC_HIGH_RD, 8'hff, 8'h55);
    rchk("ofs_rst", A_REM2_OFS_LO, 8'hff, 8'h00);
    wr(A_STATUS1, 8'hff);
    rchk("st1_ro", A_STATUS1, 8'hff, 8'h00);
    rchk("unmapped", 8'hfe, 8'hff, 8'h00);
    wr(A_RATE_WR, 8'h87);
    chk("avg_off", avg_en, 1'b0);
    rchk("rate_rb", A_RATE_RD, 8'hff, 8'h87);
    wr(A_RATE_WR, 8'h08);
    chk("avg_fast", avg_en, 1'b0);
  endtask

  task automatic s_chan();
    int g;
    rst(8'h0a, 4'd0);
    g = 0;
    do begin
      @(posedge clock);
      g++;
    end while (!(adc_start === 1'b1 && adc_chan === 2'd0) && g < 500);
    nstart(2'd1);
    nstart(2'd2);
    for (int c = 1; c < 4; c++) begin
      wr(A_RATE_WR, {2'b00, c[1:0], 4'ha});
      conv(2);
      nstart(2'(c - 1));
    end
    wr(A_RATE_WR, 8'h0b);
    chk("cont_avg", avg_en, 1'b1);
    g = 0;
    // the fastest periodic rate gives at most 9 results in 60 cycles here
    repeat (60) begin
      @(posedge clock);
      if (meas.valid === 1'b1) g++;
    end
    chk("cont_rate", {9'h000, g > 9}, 10'h001);
  endtask

  task automatic s_low_irq();
    rst(8'h0a, 4'd3);
    wr(A_LOC_LOW_WR, 8'h20);
    setloc(10'h080);
    chk("irq_low", sh_n, 1'b0);
    rchk("st2_irq", A_STATUS2, 8'h01, 8'h01);
    rchk("st1_hold", A_STATUS1, 8'h7f, 8'h20);
    wr(A_STATUS1, 8'h00);
    setloc(10'h100);
    rchk("st1_kept", A_STATUS1, 8'h7f, 8'h20);
    rchk("st1_clr", A_STATUS1, 8'h7f, 8'h00);
    chk("latch_kept", sh_n, 1'b0);
    @(posedge clock);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("latch_clr", sh_n, 1'b1);
    rchk("st2_idle", A_STATUS2, 8'h01, 8'h00);
  endtask

  task automatic s_open_mask();
    rst(8'h0a, 4'd9);
    wr(A_CFG1_WR, 8'h02);
    @(posedge clock);
    open_m <= 3'b010;
    conv(4);
    rchk("st1_open", A_STATUS1, 8'h7f, 8'h04);
    chk("rem_one_irq_block", sh_n, 1'b1);
    wr(A_CFG1_WR, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk("unmasked", sh_n, 1'b0);
    @(posedge clock);
    open_m <= 3'b100;
    conv(4);
    rchk("st2_open", A_STATUS2, 8'h1f, 8'h05);
    wr(A_CFG1_WR, 8'h80);
    repeat (3) @(posedge clock);
    #1;
    chk("mask_all", sh_n, 1'b1);
    rchk("st2_masked", A_STATUS2, 8'h01, 8'h00);
  endtask

  task automatic s_overtemp_out_n();
    int g;
    rst(8'h0a, 4'd3);
    wr(A_LOC_OVERTEMP_OUT_N, 8'h50);
    setloc(10'h144);
    chk("ot_set", ot_n, 1'b0);
    setloc(10'h118);
    chk("ot_hyst", ot_n, 1'b0);
    setloc(10'h114);
    chk("ot_rel", ot_n, 1'b1);
    wr(A_REM_OVERTEMP_OUT_N, 8'h30);
    @(posedge clock);
    v1 <= 10'h0c4;
    conv(4);
    chk("ot_rem", ot_n, 1'b0);
    rchk("st1_ot", A_STATUS1, 8'h03, 8'h02);
    wr(A_CFG1_WR, 8'h40);
    repeat (40) @(posedge clock);
    #1;
    chk("stby_pin", ot_n, 1'b1);
    g = 0;
    repeat (60) begin
      @(posedge clock);
      if (adc_start === 1'b1) g++;
    end
    chk("stby_idle", g[9:0], 10'h000);
  endtask

  task automatic s_second();
    rst(8'h0a, 4'd3);
    wr(A_CFG1_WR, 8'h20);
    wr(A_LOC_LOW_WR, 8'h48);
    conv(4);
    chk("role_low", sh_n, 1'b1);
    wr(A_LOC_HIGH_WR, 8'h3c);
    conv(4);
    chk("role_high", sh_n, 1'b0);
    setloc(10'h0d0);
    chk("role_hyst", sh_n, 1'b0);
    setloc(10'h0c4);
    chk("role_rel", sh_n, 1'b1);
  endtask

  task automatic s_offset();
    rst(8'h0a, 4'd3);
    wr(A_REM1_OFS_HI, 8'h04);
    wr(A_REM1_OFS_LO, 8'h40);
    conv(4);
    rchk("r1_hi", A_REM_TEMP_HI, 8'hff, 8'h44);
    rchk("r1_lo", A_REM_TEMP_LO, 8'hff, 8'h40);
    wr(A_CFG1_WR, 8'h08);
    wr(A_REM1_OFS_HI, 8'hff);
    wr(A_REM1_OFS_LO, 8'h80);
    rchk("r2_ofs_hi", A_REM2_OFS_HI, 8'hff, 8'hff);
    rchk("r2_ofs_lo", A_REM2_OFS_LO, 8'hff, 8'h80);
    wr(A_CFG1_WR, 8'h00);
    rchk("r1_kept", A_REM1_OFS_HI, 8'hff, 8'h04);
    conv(4);
    rchk("r2_hi", A_REM2_TEMP_HI, 8'hff, 8'h3f);
    rchk("r2_lo", A_REM2_TEMP_LO, 8'hff, 8'h80);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a hang counts as a mismatch and still reaches the report
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    rst_n  = 1'b0;
    req    = '0;
    ack    = 1'b0;
    v0     = 10'h100;
    v1     = 10'h100;
    v2     = 10'h100;
    open_m = 3'b000;
    lat    = 4'd3;
    s_regs();
    s_chan();
    s_low_irq();
    s_open_mask();
    s_overtemp_out_n();
    s_second();
    s_offset();
    wrap_up();
  end
endmodule // tb

`default_nettype wire

/* test/tlsa_fe_model.sv */
// conversion front-end model: answers start pulses with programmed results
`timescale 1ns/1ps
`default_nettype none

module tlsa_fe_model
  import tlsa_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       adc_start,
  input  wire logic [1:0] adc_chan,
  input  wire logic [9:0] val_loc,
  input  wire logic [9:0] val_r1,
  input  wire logic [9:0] val_r2,
  input  wire logic [2:0] open_mask,
  input  wire logic [3:0] lat,
  output var tlsa_meas_t  meas
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [1:0] ch_r;
  logic [9:0] sel;

  assign sel = (ch_r == 2'd0) ? val_loc : (ch_r == 2'd1) ? val_r1 : val_r2;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
      ch_r   <= 2'd0;
      meas   <= '0;
    end else begin
      meas.valid <= 1'b0;
      // outside a result the lines toggle each cycle between the last value and its inverse
      meas.val   <= ~meas.val;
      meas.open  <= ~meas.open;
      if (adc_start) begin
        busy_r <= 1'b1;
        cnt_r  <= lat;
        ch_r   <= adc_chan;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r     <= 1'b0;
        meas.valid <= 1'b1;
        meas.open  <= open_mask[ch_r];
        meas.val   <= sel;
      end
    end
  end
endmodule // tlsa_fe_model

`default_nettype wire
